// file: rtl/io_link_map.svh
// Field positions, codes and timing counts of the I/O link
`ifndef IO_LINK_MAP_SVH
`define IO_LINK_MAP_SVH
`define CLK_MHZ      100
`define LINK_MHZ     10
`define LCLK_HALF    (`CLK_MHZ / (2 * `LINK_MHZ))
`define ANS_SLOTS    2
`define TY_MSB       5
`define TY_LSB       3
`define TY_ILL_LO    3'h0
`define TY_READ      3'h1
`define TY_WRITE     3'h2
`define TY_MODIFY    3'h3
`define TY_RD_DATA   3'h4
`define TY_ERR_DATA  3'h5
`define TY_ERROR     3'h6
`define TY_ILL_HI    3'h7
`define CRED_RD      1
`define CRED_WR      0
`define AN_ACK       1
`define AN_NACK      0
`define CNT_W        8
`endif

// file: rtl/io_link_pkg.sv
// Types and helper functions shared by both link ends
`include "io_link_map.svh"
package io_link_pkg;
   typedef struct packed {
      logic        act;
      logic [8:0]  dst;
      logic        dpar;
      logic [8:0]  src;
      logic        spar;
      logic [5:0]  typ;
      logic        tpar;
      logic [31:0] data;
      logic [3:0]  bpar;
   } xfer_t;

   typedef enum logic [1:0] {SEL_NONE, SEL_CMD, SEL_RSP} sel_t;

   function automatic logic odd_par(input logic [31:0] v);
      return ~^v;
   endfunction

   function automatic xfer_t mk_xfer(input logic [8:0]  dst,
                                     input logic [8:0]  src,
                                     input logic [5:0]  typ,
                                     input logic [31:0] data);
      xfer_t x;
      x.act  = 1'b1;
      x.dst  = dst;
      x.dpar = odd_par(32'(dst));
      x.src  = src;
      x.spar = odd_par(32'(src));
      x.typ  = typ;
      x.tpar = odd_par(32'(typ));
      x.data = data;
      for (int i = 0; i < 4; i++) begin
         x.bpar[i] = odd_par(32'(data[8*i +: 8]));
      end
      return x;
   endfunction

   function automatic logic xfer_ok(input xfer_t x);
      logic ok;
      ok = (x.dpar == odd_par(32'(x.dst))) && (x.spar == odd_par(32'(x.src)));
      ok = ok && (x.tpar == odd_par(32'(x.typ)));
      for (int i = 0; i < 4; i++) begin
         ok = ok && (x.bpar[i] == odd_par(32'(x.data[8*i +: 8])));
      end
      ok = ok && (x.typ[`TY_MSB:`TY_LSB] != `TY_ILL_LO);
      ok = ok && (x.typ[`TY_MSB:`TY_LSB] != `TY_ILL_HI);
      return ok;
   endfunction

   function automatic logic is_rd(input logic [5:0] t);
      return (t[`TY_MSB:`TY_LSB] == `TY_READ) || (t[`TY_MSB:`TY_LSB] == `TY_MODIFY);
   endfunction

   function automatic logic is_wr(input logic [5:0] t);
      return t[`TY_MSB:`TY_LSB] == `TY_WRITE;
   endfunction
endpackage

// file: rtl/io_point_link.sv
// Link wires between the system side end and the adapter end
`timescale 1ns/1ns
interface io_point_link;
   logic               lclk;
   logic               grant;
   io_link_pkg::xfer_t dev_x;
   io_link_pkg::xfer_t ada_x;
   io_link_pkg::xfer_t bus;
   logic               dev_oe;
   logic               ada_oe;
   logic [1:0]         dev_an;
   logic [1:0]         ada_an;
   logic [1:0]         an;
   logic               dev_an_oe;
   logic               ada_an_oe;
   logic [1:0]         dev_cred;
   logic [1:0]         ada_cred;

   assign bus = dev_oe ? dev_x : (ada_oe ? ada_x : '0);
   assign an  = (dev_an_oe ? dev_an : 2'h0) | (ada_an_oe ? ada_an : 2'h0);

   modport dev_end (output lclk, grant, dev_x, dev_oe, dev_an, dev_an_oe, dev_cred,
                    input bus, an, ada_cred);
   modport ada_end (output ada_x, ada_oe, ada_an, ada_an_oe, ada_cred,
                    input lclk, grant, bus, an, dev_cred);
endinterface

// file: rtl/io_adapter_link_end.sv
// Adapter end of the I/O link
`timescale 1ns/1ns
`include "io_link_map.svh"
module io_adapter_link_end #(
   parameter logic [8:0] MY_ADDR = 9'h001,
   parameter int         RD_BUFS = 2,
   parameter int         WR_BUFS = 2
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   io_point_link.ada_end    lnk,
   input  wire logic        i_tx_valid,
   input  wire logic [8:0]  i_tx_dst,
   input  wire logic [5:0]  i_tx_type,
   input  wire logic [31:0] i_tx_data,
   output logic             o_tx_ready,
   output logic             o_done_valid,
   output logic             o_done_ack,
   output logic             o_done_nack,
   output logic             o_rx_valid,
   output logic [8:0]       o_rx_src,
   output logic [5:0]       o_rx_type,
   output logic [31:0]      o_rx_data,
   input  wire logic        i_rd_free,
   input  wire logic        i_wr_free
);
   localparam int W = `CNT_W;

   logic               ls1_q, ls2_q, ls3_q, gs1_q, gs2_q;
   io_link_pkg::xfer_t bs1_q, bs2_q, tx_q, x_q;
   logic [1:0]         as1_q, as2_q, cs1_q, cs2_q, an_q, cred_q;
   logic               tx_empty_q, oe_q, an_oe_q, aph_q, apk_q;
   logic [2:0]         sp_q;
   logic [W-1:0]       pr_q, pw_q, rp_q, wp_q;

   // Edge of the link clock, seen through the synchroniser
   wire rise    = ls2_q && !ls3_q;
   wire self_tx = tx_q.dst == MY_ADDR;                                         // see R4
   wire is_rd_w = io_link_pkg::is_rd(tx_q.typ);
   wire is_wr_w = io_link_pkg::is_wr(tx_q.typ);
   wire cred_ok = self_tx || (is_rd_w ? pr_q != '0 : (is_wr_w ? pw_q != '0 : 1'b1)); // see R9
   wire send    = rise && gs2_q && !tx_empty_q && cred_ok;                     // see R12
   wire hit     = bs2_q.act && (bs2_q.dst == MY_ADDR);
   wire ok      = io_link_pkg::xfer_ok(bs2_q);                                 // see R15
   wire dec_rd  = send && !self_tx && is_rd_w;                                 // see R7
   wire dec_wr  = send && !self_tx && is_wr_w;
   wire inc_rd  = rise && cs2_q[`CRED_RD];
   wire inc_wr  = rise && cs2_q[`CRED_WR];
   wire give_rd = rise && rp_q != '0;                                          // see R8
   wire give_wr = rise && wp_q != '0;

   assign lnk.ada_x     = x_q;
   assign lnk.ada_oe    = oe_q;
   assign lnk.ada_an    = an_q;
   assign lnk.ada_an_oe = an_oe_q;
   assign lnk.ada_cred  = cred_q;
   assign o_tx_ready    = tx_empty_q;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {ls1_q, ls2_q, ls3_q, gs1_q, gs2_q} <= 5'h00;
         {bs1_q, bs2_q, as1_q, as2_q, cs1_q, cs2_q} <= '0;
      end else begin
         {ls1_q, ls2_q, ls3_q} <= {lnk.lclk, ls1_q, ls2_q};
         {gs1_q, gs2_q}        <= {lnk.grant, gs1_q};
         {bs1_q, bs2_q}        <= {lnk.bus, bs1_q};
         {as1_q, as2_q}        <= {lnk.an, as1_q};
         {cs1_q, cs2_q}        <= {lnk.dev_cred, cs1_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_empty_q <= 1'b1;
         tx_q       <= '0;
         x_q        <= '0;
         oe_q       <= 1'b0;
      end else begin
         if (i_tx_valid && tx_empty_q) begin
            tx_q       <= io_link_pkg::mk_xfer(i_tx_dst, MY_ADDR, i_tx_type, i_tx_data); // see R13
            tx_empty_q <= 1'b0;
         end else if (send) begin
            tx_empty_q <= 1'b1;
         end
         if (rise) begin
            oe_q <= send;
         end
         if (send) begin
            x_q <= tx_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {aph_q, apk_q, an_oe_q} <= 3'h0;
         an_q         <= 2'h0;
         sp_q         <= 3'h0;
         o_done_valid <= 1'b0;
         o_done_ack   <= 1'b0;
         o_done_nack  <= 1'b0;
         o_rx_valid   <= 1'b0;
         o_rx_src     <= '0;
         o_rx_type    <= '0;
         o_rx_data    <= '0;
      end else begin
         o_rx_valid   <= rise && hit && ok;                                    // see R5
         o_done_valid <= rise && sp_q[2];                                      // see R16
         if (rise) begin
            aph_q   <= hit;
            apk_q   <= ok;
            an_oe_q <= aph_q;                                                  // see R17
            an_q    <= aph_q ? {apk_q, !apk_q} : 2'h0;                         // see R14
            sp_q    <= {sp_q[1:0], send};
            o_done_ack  <= as2_q[`AN_ACK];
            o_done_nack <= as2_q[`AN_NACK];
            o_rx_src  <= bs2_q.src;
            o_rx_type <= bs2_q.typ;
            o_rx_data <= bs2_q.data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pr_q   <= '0;
         pw_q   <= '0;
         rp_q   <= W'(RD_BUFS);                                                // see R6
         wp_q   <= W'(WR_BUFS);
         cred_q <= 2'h0;
      end else begin
         pr_q <= pr_q + W'(inc_rd) - W'(dec_rd);
         pw_q <= pw_q + W'(inc_wr) - W'(dec_wr);
         rp_q <= rp_q + W'(i_rd_free) - W'(give_rd);
         wp_q <= wp_q + W'(i_wr_free) - W'(give_wr);
         if (rise) begin
            cred_q <= {rp_q != '0, wp_q != '0};
         end
      end
   end
endmodule

// file: rtl/system_side_link_module.sv
// System side end of the I/O link, with the link clock divider and arbiter
//
// Functional notes
// R1 - Link clock is half rate, nominally 10 MHz
// R2 - Each slot moves one 32-bit word
// R3 - Slot carries source, destination, type, four bytes
// R4 - A port may address itself or its peer
// R5 - Type field tells what the payload means
// R6 - Each port advertises read and write buffer credits
// R7 - Sending a command decrements the matching credit
// R8 - Freeing a buffer tells peer to increment credit
// R9 - No command while its class credit is zero
// R10 - Arbiter here; system side has priority
// R11 - Grant self for response or credited command
// R12 - All other slots go to the adapter
// R13 - Parity on source, destination, type, each byte
// R14 - Good transmission answered by ACK two slots later
// R15 - Parity or type error answered by NACK
// R16 - Neither ACK nor NACK means not received
// R17 - Only the addressed port drives ACK or NACK
// R18 - Retry after failure is optional
// R19 - A retry restarts the whole command
// R20 - Hold commands and responses between bus and link
// R21 - Type is 3-bit code plus 3-bit size
// R22 - Addresses are 4-bit bus slot, 5-bit I/O slot
// R23 - Long reads answered by several read-data responses
`timescale 1ns/1ns
`include "io_link_map.svh"
module system_side_link_module #(
   parameter logic [8:0] MY_ADDR = 9'h000,
   parameter int         RD_BUFS = 2,
   parameter int         WR_BUFS = 2,
   parameter int         HALF    = `LCLK_HALF
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   io_point_link.dev_end    lnk,
   input  wire logic        i_cmd_valid,
   input  wire logic [8:0]  i_cmd_dst,
   input  wire logic [5:0]  i_cmd_type,
   input  wire logic [31:0] i_cmd_data,
   output logic             o_cmd_ready,
   input  wire logic        i_rsp_valid,
   input  wire logic [8:0]  i_rsp_dst,
   input  wire logic [5:0]  i_rsp_type,
   input  wire logic [31:0] i_rsp_data,
   output logic             o_rsp_ready,
   output logic             o_done_valid,
   output logic             o_done_rsp,
   output logic             o_done_ack,
   output logic             o_done_nack,
   output logic             o_rx_valid,
   output logic [8:0]       o_rx_src,
   output logic [5:0]       o_rx_type,
   output logic [31:0]      o_rx_data,
   input  wire logic        i_rd_free,
   input  wire logic        i_wr_free
);
   localparam int W = `CNT_W;

   logic [W-1:0]       div_q;
   logic               lclk_q, grant_q;
   io_link_pkg::xfer_t bs1_q, bs2_q, cmd_q, rsp_q, x_q;
   logic [1:0]         as1_q, as2_q, cs1_q, cs2_q, an_q, cred_q;
   logic               cmd_empty_q, rsp_empty_q, oe_q, an_oe_q;
   logic [1:0]         aph_q, apk_q;
   io_link_pkg::sel_t  nxt_q, tag_q, sp0_q, sp1_q;
   logic [W-1:0]       pr_q, pw_q, rp_q, wp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Link clock divider and slot ticks
   wire tick = div_q == W'(HALF - 1);                                          // see R1
   wire rise = tick && !lclk_q;
   wire fall = tick && lclk_q;

   // Command class and credit check
   wire cmd_self = cmd_q.dst == MY_ADDR;                                       // see R4
   wire cmd_rd   = io_link_pkg::is_rd(cmd_q.typ);                              // see R21
   wire cmd_wr   = io_link_pkg::is_wr(cmd_q.typ);
   wire cred_ok  = cmd_self || (cmd_rd ? pr_q != '0 : (cmd_wr ? pw_q != '0 : 1'b1)); // see R9

   // Arbiter: responses first, then credited commands, else the adapter
   wire want_rsp = !rsp_empty_q && (nxt_q != io_link_pkg::SEL_RSP);            // see R11
   wire want_cmd = !cmd_empty_q && (nxt_q != io_link_pkg::SEL_CMD) && cred_ok;
   io_link_pkg::sel_t pick;
   assign pick = want_rsp ? io_link_pkg::SEL_RSP :
                 (want_cmd ? io_link_pkg::SEL_CMD : io_link_pkg::SEL_NONE);    // see R10

   wire drv_cmd = fall && (nxt_q == io_link_pkg::SEL_CMD);
   wire drv_rsp = fall && (nxt_q == io_link_pkg::SEL_RSP);
   wire pick_c  = fall && (pick == io_link_pkg::SEL_CMD) && !cmd_self;
   wire dec_rd  = pick_c && cmd_rd;                                            // see R7
   wire dec_wr  = pick_c && cmd_wr;
   wire inc_rd  = rise && cs2_q[`CRED_RD];
   wire inc_wr  = rise && cs2_q[`CRED_WR];
   wire give_rd = fall && rp_q != '0;                                          // see R8
   wire give_wr = fall && wp_q != '0;

   // Receive check
   wire hit = bs2_q.act && (bs2_q.dst == MY_ADDR);                             // see R22
   wire ok  = io_link_pkg::xfer_ok(bs2_q);                                     // see R15

   assign lnk.lclk      = lclk_q;
   assign lnk.grant     = grant_q;
   assign lnk.dev_x     = x_q;
   assign lnk.dev_oe    = oe_q;
   assign lnk.dev_an    = an_q;
   assign lnk.dev_an_oe = an_oe_q;
   assign lnk.dev_cred  = cred_q;
   assign o_cmd_ready   = cmd_empty_q;
   assign o_rsp_ready   = rsp_empty_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Divider and input synchronisers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q  <= '0;
         lclk_q <= 1'b0;
         {bs1_q, bs2_q, as1_q, as2_q, cs1_q, cs2_q} <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + W'(1);
         if (tick) begin
            lclk_q <= !lclk_q;
         end
         {bs1_q, bs2_q} <= {lnk.bus, bs1_q};
         {as1_q, as2_q} <= {lnk.an, as1_q};
         {cs1_q, cs2_q} <= {lnk.ada_cred, cs1_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Holding registers between the system bus side and the link
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_empty_q <= 1'b1;
         rsp_empty_q <= 1'b1;
         cmd_q       <= '0;
         rsp_q       <= '0;
      end else begin
         if (i_cmd_valid && cmd_empty_q) begin                                 // see R20
            cmd_q       <= io_link_pkg::mk_xfer(i_cmd_dst, MY_ADDR, i_cmd_type, i_cmd_data);
            cmd_empty_q <= 1'b0;
         end else if (drv_cmd) begin
            cmd_empty_q <= 1'b1;
         end
         if (i_rsp_valid && rsp_empty_q) begin                                 // see R23
            rsp_q       <= io_link_pkg::mk_xfer(i_rsp_dst, MY_ADDR, i_rsp_type, i_rsp_data);
            rsp_empty_q <= 1'b0;
         end else if (drv_rsp) begin
            rsp_empty_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Slot ownership and link drive, updated at the slot boundary on the link clock fall
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nxt_q   <= io_link_pkg::SEL_NONE;
         tag_q   <= io_link_pkg::SEL_NONE;
         grant_q <= 1'b0;
         x_q     <= '0;
         oe_q    <= 1'b0;
      end else if (fall) begin
         nxt_q   <= pick;
         grant_q <= pick == io_link_pkg::SEL_NONE;                             // see R12
         tag_q   <= nxt_q;
         oe_q    <= nxt_q != io_link_pkg::SEL_NONE;                            // see R3
         case (nxt_q)
            io_link_pkg::SEL_CMD: begin
               x_q <= cmd_q;                                                   // see R2
            end
            io_link_pkg::SEL_RSP: begin
               x_q <= rsp_q;                                                   // see R13
            end
            default: begin
               x_q <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive, answer and completion tracking
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aph_q        <= 2'h0;
         apk_q        <= 2'h0;
         an_oe_q      <= 1'b0;
         an_q         <= 2'h0;
         sp0_q        <= io_link_pkg::SEL_NONE;
         sp1_q        <= io_link_pkg::SEL_NONE;
         o_done_valid <= 1'b0;
         o_done_rsp   <= 1'b0;
         o_done_ack   <= 1'b0;
         o_done_nack  <= 1'b0;
         o_rx_valid   <= 1'b0;
         o_rx_src     <= '0;
         o_rx_type    <= '0;
         o_rx_data    <= '0;
      end else begin
         o_rx_valid   <= rise && hit && ok;                                    // see R5
         o_done_valid <= rise && (sp1_q != io_link_pkg::SEL_NONE);             // see R16
         if (rise) begin
            aph_q <= {aph_q[0], hit};
            apk_q <= {apk_q[0], ok};
            sp0_q <= tag_q;
            sp1_q <= sp0_q;
            o_done_rsp  <= sp1_q == io_link_pkg::SEL_RSP;
            o_done_ack  <= as2_q[`AN_ACK];                                     // see R18
            o_done_nack <= as2_q[`AN_NACK];                                    // see R19
            o_rx_src    <= bs2_q.src;
            o_rx_type   <= bs2_q.typ;
            o_rx_data   <= bs2_q.data;
         end
         if (fall) begin
            an_oe_q <= aph_q[1];                                               // see R17
            an_q    <= aph_q[1] ? {apk_q[1], !apk_q[1]} : 2'h0;                // see R14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Credits held for the adapter and credits given to it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pr_q   <= '0;
         pw_q   <= '0;
         rp_q   <= W'(RD_BUFS);                                                // see R6
         wp_q   <= W'(WR_BUFS);
         cred_q <= 2'h0;
      end else begin
         pr_q <= pr_q + W'(inc_rd) - W'(dec_rd);
         pw_q <= pw_q + W'(inc_wr) - W'(dec_wr);
         rp_q <= rp_q + W'(i_rd_free) - W'(give_rd);
         wp_q <= wp_q + W'(i_wr_free) - W'(give_wr);
         if (fall) begin
            cred_q <= {give_rd, give_wr};
         end
      end
   end
endmodule

// file: test/io_link_port_protocol_chk.sv
// Concurrent checks on the wires between the two link ends
`timescale 1ns/1ns
`include "io_link_map.svh"
module io_link_port_protocol_chk (
   input wire logic               i_clk,
   input wire logic               i_rst_n,
   input wire logic               lclk,
   input wire io_link_pkg::xfer_t bus,
   input wire logic               dev_oe,
   input wire logic               ada_oe,
   input wire logic [1:0]         an,
   input wire logic [1:0]         dev_cred,
   input wire logic [1:0]         ada_cred
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////
   wire [2:0] code    = bus.typ[`TY_MSB:`TY_LSB];
   wire       good_ty = (code != `TY_ILL_LO) && (code != `TY_ILL_HI);
   wire       for_end = bus.act && (bus.dst[8:1] == 8'h00);
   wire       hdr_ok  = (bus.dpar == ~^bus.dst) && (bus.spar == ~^bus.src)
                        && (bus.tpar == ~^bus.typ);
   wire       byte_ok = (bus.bpar[0] == ~^bus.data[7:0]) && (bus.bpar[1] == ~^bus.data[15:8])
                        && (bus.bpar[2] == ~^bus.data[23:16]) && (bus.bpar[3] == ~^bus.data[31:24]);
   ////////////////////////////////////////////////////////////
   lclk_period_a: assert property ($rose(lclk) |-> lclk[*5] ##1 !lclk[*5] ##1 lclk)
      else $error("link clock period wrong");
   owner_single_a: assert property ($rose(lclk) ##2 1'b1 |-> !(dev_oe && ada_oe))
      else $error("both ends drive one slot");
   field_parity_a: assert property ($rose(lclk) ##2 (dev_oe || ada_oe) |-> hdr_ok && byte_ok)
      else $error("field parity wrong");
   good_ack_a: assert property ($rose(lclk) ##2 (for_end && good_ty) |-> ##[10:30] an[`AN_ACK])
      else $error("good transmission not acknowledged");
   bad_nack_a: assert property ($rose(lclk) ##2 (for_end && !good_ty) |-> ##[10:30] an[`AN_NACK])
      else $error("bad type not refused");
   dev_edge_a: assert property ($changed(dev_oe) |-> $fell(lclk))
      else $error("system end drive off slot boundary");
   dev_cred_a: assert property ($rose(dev_cred[`CRED_WR]) |-> dev_cred[`CRED_WR][*8])
      else $error("system credit pulse short");
   ada_cred_a: assert property ($rose(ada_cred[`CRED_RD]) |-> ada_cred[`CRED_RD][*8])
      else $error("adapter credit pulse short");
endmodule

// file: test/io_link_port_protocol_tb.sv
// Self-checking bench joining both link ends through the link interface
`timescale 1ns/1ns
`include "io_link_map.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module io_link_port_protocol_tb;
   logic        i_clk = 1'b0;
   logic        i_rst_n;
   logic [2:0]  vld;
   logic [2:0]  rdy;
   logic [3:0]  frees;
   logic [8:0]  dst;
   logic [5:0]  typ;
   logic [31:0] dat;
   logic [1:0]  dv, ack, nack, rxv;
   logic        s_drsp;
   logic [8:0]  rsrc [2];
   logic [5:0]  rty [2];
   logic [31:0] rdat [2];
   int          err_total = 0;
   int          compares = 0;
   int          i;
   logic [2:0]  c;
   logic        ok_ty;
   ////////////////////////////////////////////////////////////
   always #5 i_clk = ~i_clk;
   io_point_link lnk ();
   system_side_link_module i_system_side_link_module (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
      .i_cmd_valid(vld[0]), .i_cmd_dst(dst), .i_cmd_type(typ), .i_cmd_data(dat),
      .o_cmd_ready(rdy[0]), .i_rsp_valid(vld[1]), .i_rsp_dst(dst), .i_rsp_type(typ),
      .i_rsp_data(dat), .o_rsp_ready(rdy[1]), .o_done_valid(dv[0]), .o_done_rsp(s_drsp),
      .o_done_ack(ack[0]), .o_done_nack(nack[0]), .o_rx_valid(rxv[0]), .o_rx_src(rsrc[0]),
      .o_rx_type(rty[0]), .o_rx_data(rdat[0]), .i_rd_free(frees[0]), .i_wr_free(frees[1]));
   io_adapter_link_end i_io_adapter_link_end (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
      .i_tx_valid(vld[2]), .i_tx_dst(dst), .i_tx_type(typ), .i_tx_data(dat),
      .o_tx_ready(rdy[2]), .o_done_valid(dv[1]), .o_done_ack(ack[1]), .o_done_nack(nack[1]),
      .o_rx_valid(rxv[1]), .o_rx_src(rsrc[1]), .o_rx_type(rty[1]), .o_rx_data(rdat[1]),
      .i_rd_free(frees[2]), .i_wr_free(frees[3]));
   io_link_port_protocol_chk i_io_link_port_protocol_chk (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .lclk(lnk.lclk), .bus(lnk.bus), .dev_oe(lnk.dev_oe),
      .ada_oe(lnk.ada_oe), .an(lnk.an), .dev_cred(lnk.dev_cred), .ada_cred(lnk.ada_cred));
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic send(input int w, input logic [8:0] d, input logic [5:0] t,
                       input logic [31:0] v);
      logic took;
      took = 1'b0;
      @(posedge i_clk);
      dst <= d;
      typ <= t;
      dat <= v;
      vld <= 3'(3'h1 << w);
      for (int n = 0; n < 3000 && !took; n++) begin
         @(posedge i_clk);
         took = (rdy[w] === 1'b1);
      end
      vld <= 3'h0;
      `CHK("req_taken", 1'b1, took)
   endtask

   task automatic wait_rx(input int e, input logic hit, input logic [8:0] s,
                          input logic [5:0] t, input logic [31:0] v, input int lim);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < lim && !seen; n++) begin
         @(posedge i_clk);
         seen = (rxv[e] === 1'b1);
      end
      `CHK("rx_valid", hit, seen)
      if (seen) begin
         `CHK("rx_src", s, rsrc[e])
         `CHK("rx_type", t, rty[e])
         `CHK("rx_data", v, rdat[e])
      end
   endtask

   task automatic wait_done(input int e, input logic a, input logic k, input logic r);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 600 && !seen; n++) begin
         @(posedge i_clk);
         seen = (dv[e] === 1'b1);
      end
      `CHK("done_valid", 1'b1, seen)
      `CHK("done_ack", a, ack[e])
      `CHK("done_nack", k, nack[e])
      if (e == 0) `CHK("done_rsp", r, s_drsp)
   endtask

   task automatic free_buf(input int k);
      @(posedge i_clk);
      frees <= 4'(4'h1 << k);
      @(posedge i_clk);
      frees <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      i_rst_n = 1'b0;
      vld = 3'h0;
      frees = 4'h0;
      dst = 9'h000;
      typ = 6'h00;
      dat = 32'h0;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (100) @(posedge i_clk);
      send(0, 9'h001, {`TY_WRITE, 3'h4}, 32'h1234ABCD);
      wait_rx(1, 1'b1, 9'h000, {`TY_WRITE, 3'h4}, 32'h1234ABCD, 300);
      wait_done(0, 1'b1, 1'b0, 1'b0);
      free_buf(3);
      for (i = 0; i < 8; i++) begin
         c = 3'(i);
         ok_ty = (c != `TY_ILL_LO) && (c != `TY_ILL_HI);
         send(1, 9'h001, {c, 3'h4}, {29'h0A5C3E1, c});
         if (ok_ty) wait_rx(1, 1'b1, 9'h000, {c, 3'h4}, {29'h0A5C3E1, c}, 300);
         wait_done(0, ok_ty, !ok_ty, 1'b1);
      end
      send(2, 9'h000, {`TY_READ, 3'h4}, 32'h0BADF00D);
      wait_rx(0, 1'b1, 9'h001, {`TY_READ, 3'h4}, 32'h0BADF00D, 300);
      wait_done(1, 1'b1, 1'b0, 1'b0);
      free_buf(0);
      send(0, 9'h000, {`TY_MODIFY, 3'h4}, 32'h5A5A0F0F);
      wait_rx(0, 1'b1, 9'h000, {`TY_MODIFY, 3'h4}, 32'h5A5A0F0F, 300);
      wait_done(0, 1'b1, 1'b0, 1'b0);
      send(2, 9'h001, {`TY_READ, 3'h2}, 32'h00C0FFEE);
      wait_rx(1, 1'b1, 9'h001, {`TY_READ, 3'h2}, 32'h00C0FFEE, 300);
      wait_done(1, 1'b1, 1'b0, 1'b0);
      send(1, 9'h1FF, {`TY_RD_DATA, 3'h5}, 32'h77770000);
      wait_done(0, 1'b0, 1'b0, 1'b1);
      for (i = 0; i < 3; i++) begin
         send(2, 9'h000, {`TY_WRITE, 3'h4}, 32'hCAFE0000 + 32'(i));
         wait_rx(0, i < 2, 9'h001, {`TY_WRITE, 3'h4}, 32'hCAFE0000 + 32'(i), 300);
      end
      free_buf(1);
      wait_rx(0, 1'b1, 9'h001, {`TY_WRITE, 3'h4}, 32'hCAFE0002, 300);
      for (i = 0; i < 3; i++) begin
         send(0, 9'h001, {`TY_READ, 3'h4}, 32'hBEEF0000 + 32'(i));
         wait_rx(1, i < 2, 9'h000, {`TY_READ, 3'h4}, 32'hBEEF0000 + 32'(i), 300);
      end
      free_buf(2);
      wait_rx(1, 1'b1, 9'h000, {`TY_READ, 3'h4}, 32'hBEEF0002, 300);
      summarize();
   end

   initial begin
      repeat (30000) @(posedge i_clk);
      err_total++;
      summarize();
   end
endmodule
